// ==== rtl/opm_consts.svh ====
// Constants for the operator panel menu controller
`ifndef OPM_CONSTS_SVH
`define OPM_CONSTS_SVH
`define OPM_CLK_NS 10
`define OPM_DEBOUNCE_NS 10000000
`define OPM_REPEAT_NS 200000000
`define OPM_BLINK_NS 500000000
`define OPM_BLINK_W 26
`define OPM_NUM_W 10
`define OPM_IDX_W 8
`define OPM_VAL_W 16
`define OPM_NUM_FIRST 10'h000
`define OPM_NUM_LAST 10'h3e7
`define OPM_DISP_LAST 10'h032
`define OPM_DEF_LAST 10'h063
`define OPM_SETDEP_LAST 10'h257
`define OPM_SEEK_LIMIT 10'h3e7
`define OPM_STEP_FINE 16'h0001
`define OPM_STEP_MID 16'h000a
`define OPM_STEP_FAST 16'h0064
`define OPM_SET_DEFAULT 2'h0
`endif

// ==== rtl/opm_keyin.sv ====
// Key synchroniser, debouncer and press/repeat event generator
`timescale 1ns/1ps
module opm_keyin #(
  parameter int DEBOUNCE_CYCLES = 1000000,
  parameter int REPEAT_CYCLES = 20000000,
  parameter bit REPEAT = 1'b0
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Raw key, active high
  input wire logic key_in,
  // Debounced level and press events
  output logic level_out,
  output logic press_out
);
  localparam int CMAX = (DEBOUNCE_CYCLES > REPEAT_CYCLES) ?
                        DEBOUNCE_CYCLES : REPEAT_CYCLES;
  localparam int CW = $clog2(CMAX + 1);
  localparam logic [CW-1:0] DB_END = CW'(DEBOUNCE_CYCLES - 1);
  localparam logic [CW-1:0] REP_END = CW'(REPEAT_CYCLES - 1);

  typedef struct packed {
    logic s1;
    logic s2;
    logic level;
    logic press;
    logic [CW-1:0] db;
    logic [CW-1:0] rep;
  } opm_key_state_t;

  opm_key_state_t st;
  opm_key_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = key_in;
    next_st.s2 = st.s1;
    next_st.press = 1'b0;
    if (st.s2 != st.level) begin
      // Level must hold for the full window before it is believed
      if (st.db == DB_END) begin // R24
        next_st.level = st.s2;
        next_st.press = st.s2;
        next_st.db = '0;
        next_st.rep = '0;
      end else begin
        next_st.db = st.db + 1'b1;
      end
    end else begin
      next_st.db = '0;
      if (REPEAT && st.level) begin
        if (st.rep == REP_END) begin // R24
          next_st.rep = '0;
          next_st.press = 1'b1;
        end else begin
          next_st.rep = st.rep + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_out = st.level;
  assign press_out = st.press;
endmodule : opm_keyin

// ==== rtl/opm_pkg.sv ====
// Types shared by the operator panel menu controller
package opm_pkg;
`include "opm_consts.svh"

  typedef enum logic [2:0] {
    OPM_OPER  = 3'b000,
    OPM_ALARM = 3'b001,
    OPM_NUM   = 3'b010,
    OPM_IDX   = 3'b011,
    OPM_VAL   = 3'b100,
    OPM_SEEK  = 3'b101
  } opm_mode_t;

  typedef enum logic [1:0] {
    OPM_R_DISP = 2'b00,
    OPM_R_DEF  = 2'b01,
    OPM_R_SET  = 2'b10,
    OPM_R_CFG  = 2'b11
  } opm_range_t;

  typedef struct packed {
    opm_mode_t mode;
    logic seek_up;
    logic [`OPM_NUM_W-1:0] scnt;
    logic [`OPM_NUM_W-1:0] num;
    logic [`OPM_IDX_W-1:0] idx;
    logic [`OPM_VAL_W-1:0] edit;
    logic [1:0] digit;
    logic wr;
    logic start;
    logic stop;
    logic ack;
    logic [1:0] method;
    logic [1:0] set;
    logic set_show;
    logic run;
    logic ready;
    logic rev;
    logic fault;
    logic edit_led;
    logic blink;
    logic [`OPM_BLINK_W-1:0] bcnt;
  } opm_state_t;

  function automatic opm_range_t range_of(
    input logic [`OPM_NUM_W-1:0] n);
    if (n <= `OPM_DISP_LAST) begin
      range_of = OPM_R_DISP;
    end else if (n <= `OPM_DEF_LAST) begin
      range_of = OPM_R_DEF;
    end else if (n <= `OPM_SETDEP_LAST) begin
      range_of = OPM_R_SET;
    end else begin
      range_of = OPM_R_CFG;
    end
  endfunction : range_of

  function automatic logic [`OPM_NUM_W-1:0] step_num(
    input logic [`OPM_NUM_W-1:0] n, input logic up);
    if (up) begin
      step_num = (n == `OPM_NUM_LAST) ? `OPM_NUM_FIRST : n + 1'b1;
    end else begin
      step_num = (n == `OPM_NUM_FIRST) ? `OPM_NUM_LAST : n - 1'b1;
    end
  endfunction : step_num

  // A step past a limit stops there; the next press wraps
  function automatic logic [`OPM_VAL_W-1:0] val_up(
    input logic [`OPM_VAL_W-1:0] v, s, lo, hi);
    logic [`OPM_VAL_W:0] sum;
    sum = {1'b0, v} + {1'b0, s};
    if (v >= hi) begin
      val_up = lo;
    end else if (sum > {1'b0, hi}) begin
      val_up = hi;
    end else begin
      val_up = sum[`OPM_VAL_W-1:0];
    end
  endfunction : val_up

  function automatic logic [`OPM_VAL_W-1:0] val_dn(
    input logic [`OPM_VAL_W-1:0] v, s, lo, hi);
    logic [`OPM_VAL_W:0] low;
    low = {1'b0, lo} + {1'b0, s};
    if (v <= lo) begin
      val_dn = hi;
    end else if (low > {1'b0, v}) begin
      val_dn = lo;
    end else begin
      val_dn = v - s;
    end
  endfunction : val_dn

  // One hex digit wraps on its own, leaving its neighbours alone
  function automatic logic [`OPM_VAL_W-1:0] nib_step(
    input logic [`OPM_VAL_W-1:0] v, input logic [1:0] d,
    input logic up);
    logic [3:0] n;
    n = v[{d, 2'b00} +: 4];
    n = up ? n + 4'h1 : n - 4'h1;
    nib_step = v;
    nib_step[{d, 2'b00} +: 4] = n;
  endfunction : nib_step
endpackage : opm_pkg

// ==== rtl/opm_top.sv ====
// Operator panel menu controller: keys, menu modes, editing, indicators
`timescale 1ns/1ps
`include "opm_consts.svh"

// Operation
// R1 - Mode key toggles operating and parameter modes; here it only enters parameter mode, Back key returns
// R2 - Mode key held speeds raise/lower change
// R3 - Raise/lower step parameter number
// R4 - Raise/lower change value, wrapping at limits
// R5 - Raise/lower change index number
// R6 - Back key exits edit, acknowledges faults
// R7 - Back key toggles last alarm display
// R8 - Start key only when panel start source
// R9 - Halt key always stops, chosen method
// R10 - Undefined keys do nothing
// R11 - Running indicator: contactor, regulators, operating
// R12 - Ready indicator: contactor closed, awaiting enable
// R13 - Reverse indicator follows reverse speed
// R14 - Fault lit steady, warning flashes
// R15 - Edit lit in selection, flashes editable
// R16 - Edit off and value frozen if locked
// R17 - Four number ranges; display ones read-only
// R18 - Four sets, selectable, set 1 default
// R19 - Show set digit for sets 2-4
// R20 - Skip hidden parameters when filtered
// R21 - Indexed: index first, then value
// R22 - Hex words edited digit by digit
// R23 - Rate x10 with mode, x100 both
// R24 - Debounced key events with held repeat
module opm_top
  import opm_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = `OPM_DEBOUNCE_NS / `OPM_CLK_NS,
  parameter int REPEAT_CYCLES = `OPM_REPEAT_NS / `OPM_CLK_NS,
  parameter int BLINK_CYCLES = `OPM_BLINK_NS / `OPM_CLK_NS
) (
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic RSTN_IN,
  // Panel keys, raw pins, active high
  input wire logic KEY_MODE_IN,
  input wire logic KEY_RAISE_IN,
  input wire logic KEY_LOWER_IN,
  input wire logic KEY_BACK_IN,
  input wire logic KEY_START_IN,
  input wire logic KEY_HALT_IN,
  // Drive status, same clock
  input wire logic CONTACTOR_IN,
  input wire logic REG_ENABLE_IN,
  input wire logic OPERATING_IN,
  input wire logic SPEED_REVERSE_IN,
  input wire logic FAULT_STATE_IN,
  input wire logic WARNING_IN,
  // Settings
  input wire logic START_SOURCE_SELECT_IN,
  input wire logic [1:0] STOP_METHOD_SELECT_IN,
  input wire logic [1:0] ACTIVE_SET_SELECT_IN,
  input wire logic SET_INPUT_ENABLE_IN,
  input wire logic [1:0] SET_INPUT_IN,
  input wire logic DISPLAY_FILTER_SELECT_IN,
  input wire logic KEY_CODE_OK_IN,
  // Attributes of the addressed parameter
  input wire logic PAR_VISIBLE_IN,
  input wire logic PAR_INDEXED_IN,
  input wire logic PAR_HEX_IN,
  input wire logic PAR_READ_ONLY_IN,
  input wire logic [`OPM_IDX_W-1:0] PAR_INDEX_MAX_IN,
  input wire logic [`OPM_VAL_W-1:0] PAR_MIN_IN,
  input wire logic [`OPM_VAL_W-1:0] PAR_MAX_IN,
  input wire logic [`OPM_VAL_W-1:0] PAR_VALUE_IN,
  // Parameter access and display
  output logic [`OPM_NUM_W-1:0] PARAM_NUM_OUT,
  output logic [1:0] PARAM_SET_OUT,
  output logic SET_DIGIT_SHOW_OUT,
  output logic [`OPM_IDX_W-1:0] PARAM_INDEX_OUT,
  output logic [`OPM_VAL_W-1:0] VALUE_OUT,
  output logic VALUE_WRITE_OUT,
  output logic [1:0] HEX_DIGIT_OUT,
  output logic [2:0] DISPLAY_MODE_OUT,
  // Drive commands
  output logic START_CMD_OUT,
  output logic STOP_CMD_OUT,
  output logic [1:0] STOP_METHOD_OUT,
  output logic FAULT_ACK_OUT,
  // Indicators
  output logic RUN_LED_OUT,
  output logic READY_LED_OUT,
  output logic REVERSE_LED_OUT,
  output logic FAULT_LED_OUT,
  output logic EDIT_LED_OUT
);
  localparam int K_MODE = 0;
  localparam int K_RAISE = 1;
  localparam int K_LOWER = 2;
  localparam int K_BACK = 3;
  localparam int K_START = 4;
  localparam int K_HALT = 5;
  localparam logic [`OPM_BLINK_W-1:0] BLINK_END =
    `OPM_BLINK_W'(BLINK_CYCLES - 1);

  logic rst_s1;
  logic rst_n;
  logic [5:0] key_raw;
  logic [5:0] lvl;
  logic [5:0] ev;
  logic up_ev;
  logic nav;
  logic toggle;
  logic writable;
  logic [1:0] sel_set;
  logic [`OPM_VAL_W-1:0] step;
  opm_range_t rng;
  opm_state_t st;
  opm_state_t next_st;

  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // Only the six function keys exist; nothing else is decoded
  assign key_raw = {KEY_HALT_IN, KEY_START_IN, KEY_BACK_IN, // R10
                    KEY_LOWER_IN, KEY_RAISE_IN, KEY_MODE_IN};

  for (genvar i = 0; i < 6; i++) begin : g_key
    opm_keyin #(
      .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
      .REPEAT_CYCLES(REPEAT_CYCLES),
      .REPEAT(i == K_RAISE || i == K_LOWER)
    ) u_key ( // R24
      .clk_in(MCLK_IN),
      .rst_n_in(rst_n),
      .key_in(key_raw[i]),
      .level_out(lvl[i]),
      .press_out(ev[i])
    );
  end

  assign up_ev = ev[K_RAISE];
  assign nav = ev[K_RAISE] | ev[K_LOWER];
  // A mode press while stepping only accelerates
  assign toggle = ev[K_MODE] & ~lvl[K_RAISE] & ~lvl[K_LOWER]; // R2
  assign rng = range_of(st.num); // R17
  assign writable = KEY_CODE_OK_IN && !PAR_READ_ONLY_IN // R16
                    && rng != OPM_R_DISP; // R17
  assign sel_set = SET_INPUT_ENABLE_IN ? SET_INPUT_IN // R18
                                       : ACTIVE_SET_SELECT_IN;
  assign step = (lvl[K_RAISE] && lvl[K_LOWER]) ? `OPM_STEP_FAST // R23
              : lvl[K_MODE] ? `OPM_STEP_MID : `OPM_STEP_FINE; // R2

  always_comb begin
    next_st = st;
    next_st.wr = 1'b0;
    next_st.start = 1'b0;
    next_st.stop = 1'b0;
    next_st.ack = 1'b0;
    unique case (st.mode)
      OPM_OPER: begin
        if (toggle) begin
          next_st.mode = OPM_NUM; // R1
        end else if (ev[K_BACK]) begin
          next_st.mode = OPM_ALARM; // R7
        end
      end
      OPM_ALARM: begin
        if (toggle) begin
          next_st.mode = OPM_NUM;
        end else if (ev[K_BACK]) begin
          next_st.mode = OPM_OPER; // R7
        end
      end
      OPM_NUM: begin
        if (ev[K_BACK]) begin
          next_st.mode = OPM_OPER; // R6
        end else if (toggle && PAR_INDEXED_IN) begin
          next_st.mode = OPM_IDX; // R21
          next_st.idx = '0;
        end else if (toggle) begin
          next_st.mode = OPM_VAL;
          next_st.edit = PAR_VALUE_IN;
          next_st.digit = 2'h0;
        end else if (nav) begin
          next_st.num = step_num(st.num, up_ev); // R3
          next_st.seek_up = up_ev;
          next_st.scnt = '0;
          next_st.mode = OPM_SEEK;
        end
      end
      OPM_SEEK: begin
        // Attributes follow the new number one cycle later
        if (ev[K_BACK]) begin
          next_st.mode = OPM_OPER;
        end else if (!DISPLAY_FILTER_SELECT_IN || PAR_VISIBLE_IN
                     || st.scnt == `OPM_SEEK_LIMIT) begin
          next_st.mode = OPM_NUM;
        end else begin
          next_st.num = step_num(st.num, st.seek_up); // R20
          next_st.scnt = st.scnt + 1'b1;
        end
      end
      OPM_IDX: begin
        if (ev[K_BACK]) begin
          next_st.mode = OPM_OPER; // R6
        end else if (toggle) begin
          next_st.mode = OPM_VAL; // R21
          next_st.edit = PAR_VALUE_IN;
          next_st.digit = 2'h0;
        end else if (nav && up_ev) begin
          next_st.idx = (st.idx >= PAR_INDEX_MAX_IN) ? '0 // R5
                                                     : st.idx + 1'b1;
        end else if (nav) begin
          next_st.idx = (st.idx == '0) ? PAR_INDEX_MAX_IN // R5
                                       : st.idx - 1'b1;
        end
      end
      OPM_VAL: begin
        if (ev[K_BACK]) begin
          next_st.mode = OPM_OPER; // R6
        end else if (toggle) begin
          next_st.mode = OPM_NUM; // R1
        end else if (nav && writable) begin // R16
          if (PAR_HEX_IN && lvl[K_MODE]) begin
            next_st.digit = up_ev ? st.digit + 2'h1 // R22
                                  : st.digit - 2'h1;
          end else if (PAR_HEX_IN) begin
            next_st.edit = nib_step(st.edit, st.digit, up_ev); // R22
            next_st.wr = 1'b1;
          end else begin
            next_st.edit = up_ev // R4
              ? val_up(st.edit, step, PAR_MIN_IN, PAR_MAX_IN)
              : val_dn(st.edit, step, PAR_MIN_IN, PAR_MAX_IN);
            next_st.wr = 1'b1;
          end
        end
      end
      default: begin
        next_st.mode = OPM_OPER;
      end
    endcase

    next_st.ack = ev[K_BACK]; // R6
    next_st.stop = ev[K_HALT]; // R9
    next_st.method = STOP_METHOD_SELECT_IN; // R9
    next_st.start = ev[K_START] && START_SOURCE_SELECT_IN; // R8
    next_st.set = (rng == OPM_R_SET) ? sel_set : `OPM_SET_DEFAULT; // R18
    next_st.set_show = (rng == OPM_R_SET) // R19
                       && sel_set != `OPM_SET_DEFAULT;

    if (st.bcnt == BLINK_END) begin
      next_st.bcnt = '0;
      next_st.blink = ~st.blink;
    end else begin
      next_st.bcnt = st.bcnt + 1'b1;
    end

    next_st.run = CONTACTOR_IN && REG_ENABLE_IN && OPERATING_IN; // R11
    next_st.ready = CONTACTOR_IN && !REG_ENABLE_IN; // R12
    next_st.rev = SPEED_REVERSE_IN; // R13
    next_st.fault = FAULT_STATE_IN || (WARNING_IN && st.blink); // R14
    unique case (st.mode)
      OPM_NUM, OPM_SEEK, OPM_IDX: next_st.edit_led = 1'b1; // R15
      OPM_VAL: next_st.edit_led = writable && st.blink; // R16
      default: next_st.edit_led = 1'b0;
    endcase
  end

  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign PARAM_NUM_OUT = st.num;
  assign PARAM_SET_OUT = st.set;
  assign SET_DIGIT_SHOW_OUT = st.set_show;
  assign PARAM_INDEX_OUT = st.idx;
  assign VALUE_OUT = st.edit;
  assign VALUE_WRITE_OUT = st.wr;
  assign HEX_DIGIT_OUT = st.digit;
  assign DISPLAY_MODE_OUT = st.mode;
  assign START_CMD_OUT = st.start;
  assign STOP_CMD_OUT = st.stop;
  assign STOP_METHOD_OUT = st.method;
  assign FAULT_ACK_OUT = st.ack;
  assign RUN_LED_OUT = st.run;
  assign READY_LED_OUT = st.ready;
  assign REVERSE_LED_OUT = st.rev;
  assign FAULT_LED_OUT = st.fault;
  assign EDIT_LED_OUT = st.edit_led;

  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!rst_n);

  property p_halt_stop;
    ev[K_HALT] |=> STOP_CMD_OUT && STOP_METHOD_OUT ==
                   $past(STOP_METHOD_SELECT_IN);
  endproperty
  a_halt_stop: assert property (p_halt_stop) // R9
    else $error("halt press gave no stop command");

  property p_start_gate;
    ev[K_START] && !START_SOURCE_SELECT_IN |=> !START_CMD_OUT;
  endproperty
  a_start_gate: assert property (p_start_gate) // R8
    else $error("start issued without panel start source");

  property p_back_exit;
    st.mode inside {OPM_NUM, OPM_IDX, OPM_VAL} && ev[K_BACK]
      |=> st.mode == OPM_OPER && FAULT_ACK_OUT;
  endproperty
  a_back_exit: assert property (p_back_exit) // R6
    else $error("back key did not exit and acknowledge");

  property p_toggle;
    st.mode == OPM_OPER && toggle |=> DISPLAY_MODE_OUT == OPM_NUM;
  endproperty
  a_toggle: assert property (p_toggle) // R1
    else $error("mode key did not enter parameter mode");

  property p_wrap_up;
    st.mode == OPM_VAL && writable && !PAR_HEX_IN && up_ev
      && st.edit >= PAR_MAX_IN && !ev[K_BACK]
      |=> VALUE_OUT == $past(PAR_MIN_IN) && VALUE_WRITE_OUT;
  endproperty
  a_wrap_up: assert property (p_wrap_up) // R4
    else $error("raise at maximum did not wrap to minimum");

  property p_locked;
    st.mode == OPM_VAL && !writable && nav
      |=> $stable(VALUE_OUT) && !VALUE_WRITE_OUT ##1 !EDIT_LED_OUT;
  endproperty
  a_locked: assert property (p_locked) // R16
    else $error("locked value changed or edit lit");

  property p_accel;
    st.mode == OPM_VAL && writable && !PAR_HEX_IN && up_ev
      && lvl[K_MODE] && !lvl[K_LOWER] && st.edit < PAR_MAX_IN && !ev[K_BACK]
      && {1'b0, st.edit} + 17'h0000a <= {1'b0, PAR_MAX_IN}
      |=> VALUE_OUT == $past(st.edit) + 16'h000a;
  endproperty
  a_accel: assert property (p_accel) // R23
    else $error("mode key did not give tenfold step");

  property p_run_led;
    !CONTACTOR_IN |=> !RUN_LED_OUT && !READY_LED_OUT;
  endproperty
  a_run_led: assert property (p_run_led) // R11
    else $error("run or ready lit with contactor open");

  property p_fault_led;
    FAULT_STATE_IN [*2] |=> FAULT_LED_OUT && $past(FAULT_LED_OUT);
  endproperty
  a_fault_led: assert property (p_fault_led) // R14
    else $error("fault indicator not steady in fault state");
endmodule : opm_top

// ==== test/opm_operator.sv ====
// Operator model that presses and releases the panel keys
`timescale 1ns/1ps
module opm_operator (
  // Clock
  input wire logic clk_in,
  // Keys {mode, raise, lower, back, start, halt}, high while pressed
  output logic [5:0] keys_out
);
  initial keys_out = 6'h00;

  // Held for hold cycles; a hold under debounce plus repeat gives one event per press
  task automatic press(input logic [5:0] k, input int hold);
    @(posedge clk_in);
    #1 keys_out = k;
    repeat (hold) @(posedge clk_in);
    #1 keys_out = 6'h00;
    // Long release gap keeps presses apart
    repeat (16) @(posedge clk_in);
    #2;
  endtask : press
endmodule : opm_operator

// ==== test/testbench.sv ====
// Self-checking bench for the operator panel menu controller
`timescale 1ns/1ps
`include "opm_consts.svh"
module testbench;
  import opm_pkg::*;
  localparam logic [5:0] MODE = 6'h20, RAISE = 6'h10, LOWER = 6'h08;
  localparam logic [5:0] BACK = 6'h04, START = 6'h02, HALT = 6'h01;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  wire [5:0] keys;
  logic cont = 0, regen = 0, oper = 0, rev = 0, flt = 0, warn = 0;
  logic src = 0, fsel = 0, kok = 1, ro = 0, sen = 0, hex = 0, jump = 0;
  logic [15:0] pmin = 16'h0000, pmax = 16'h03e8, pval = 16'h03e8;
  logic [9:0] goal = 10'h000;
  logic [1:0] smeth = 2'h0, aset = 2'h0, sin = 2'h0;
  logic vis, idxd;
  wire [`OPM_NUM_W-1:0] num;
  wire [1:0] pset, hdig, smo;
  wire [`OPM_IDX_W-1:0] idx;
  wire [`OPM_VAL_W-1:0] val;
  wire [2:0] dmode;
  wire sshow, wr, st, sp, ack, run_led, rdy_led, rev_led, flt_led, ed_led;
  int fail_count = 0;
  int checked = 0;
  int n_st = 0, n_sp = 0, n_ack = 0, n_wr = 0;
  int n;

  always #5 clk = ~clk;
  // Parameter 998 is hidden, 997 is indexed; jump shows only goal
  assign vis = jump ? (num === goal) : (num !== 10'h3e6);
  assign idxd = (num === 10'h3e5);

  opm_operator opm_operator_inst (.clk_in(clk), .keys_out(keys));

  opm_top #(.DEBOUNCE_CYCLES(4), .REPEAT_CYCLES(20), .BLINK_CYCLES(8))
  opm_top_inst (
    .MCLK_IN(clk), .RSTN_IN(rst_n),
    .KEY_MODE_IN(keys[5]), .KEY_RAISE_IN(keys[4]),
    .KEY_LOWER_IN(keys[3]), .KEY_BACK_IN(keys[2]),
    .KEY_START_IN(keys[1]), .KEY_HALT_IN(keys[0]),
    .CONTACTOR_IN(cont), .REG_ENABLE_IN(regen), .OPERATING_IN(oper),
    .SPEED_REVERSE_IN(rev), .FAULT_STATE_IN(flt), .WARNING_IN(warn),
    .START_SOURCE_SELECT_IN(src), .STOP_METHOD_SELECT_IN(smeth),
    .ACTIVE_SET_SELECT_IN(aset), .SET_INPUT_ENABLE_IN(sen),
    .SET_INPUT_IN(sin), .DISPLAY_FILTER_SELECT_IN(fsel),
    .KEY_CODE_OK_IN(kok), .PAR_VISIBLE_IN(vis), .PAR_INDEXED_IN(idxd),
    .PAR_HEX_IN(hex), .PAR_READ_ONLY_IN(ro),
    .PAR_INDEX_MAX_IN(8'h03), .PAR_MIN_IN(pmin),
    .PAR_MAX_IN(pmax), .PAR_VALUE_IN(pval),
    .PARAM_NUM_OUT(num), .PARAM_SET_OUT(pset), .SET_DIGIT_SHOW_OUT(sshow),
    .PARAM_INDEX_OUT(idx), .VALUE_OUT(val), .VALUE_WRITE_OUT(wr),
    .HEX_DIGIT_OUT(hdig), .DISPLAY_MODE_OUT(dmode),
    .START_CMD_OUT(st), .STOP_CMD_OUT(sp), .STOP_METHOD_OUT(smo),
    .FAULT_ACK_OUT(ack), .RUN_LED_OUT(run_led), .READY_LED_OUT(rdy_led),
    .REVERSE_LED_OUT(rev_led), .FAULT_LED_OUT(flt_led),
    .EDIT_LED_OUT(ed_led)
  );

  // Pulses are counted so no single cycle can be missed
  always @(posedge clk) begin
    if (st === 1'b1) n_st++;
    if (sp === 1'b1) n_sp++;
    if (ack === 1'b1) n_ack++;
    if (wr === 1'b1) n_wr++;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chkn(input int got, input int exp);
    chk(16'(got), 16'(exp));
  endtask : chkn

  task automatic key(input logic [5:0] k);
    opm_operator_inst.press(k, 10);
  endtask : key

  task automatic count_high(input bit fault, output int hi);
    hi = 0;
    repeat (24) begin
      @(posedge clk) #1;
      if ((fault ? flt_led : ed_led) === 1'b1) hi++;
    end
  endtask : count_high

  task automatic t_menu;
    key(MODE); chk(dmode, 3'h2);
    chk(ed_led, 1'b1);
    key(BACK); chk(dmode, 3'h0);
    chkn(n_ack, 1);
    key(BACK); chk(dmode, 3'h1);
    key(BACK); chk(dmode, 3'h0);
    key(MODE); chk(num, 10'h000);
  endtask : t_menu

  task automatic t_number;
    opm_operator_inst.press(RAISE, 2);
    chk(num, 10'h000);
    fsel = 1'b1;
    key(LOWER); chk(num, 10'h3e7);
    key(LOWER); chk(num, 10'h3e5);
    chk(dmode, 3'h2);
  endtask : t_number

  task automatic t_index;
    key(MODE); chk(dmode, 3'h3);
    chk(idx, 8'h00);
    key(LOWER); chk(idx, 8'h03);
    key(RAISE); chk(idx, 8'h00);
    key(RAISE); chk(idx, 8'h01);
    key(MODE); chk(dmode, 3'h4);
    chk(val, 16'h03e8);
    key(MODE); key(RAISE); chk(num, 10'h3e7);
  endtask : t_index

  task automatic t_value;
    key(MODE); chk(dmode, 3'h4);
    key(RAISE); chk(val, 16'h0000);
    chkn(n_wr, 1);
    key(LOWER); chk(val, 16'h03e8);
    key(RAISE); chk(val, 16'h0000);
    key(RAISE | LOWER); chk(val, 16'h0064);
    key(MODE | RAISE); chk(val, 16'h006e);
    key(MODE | LOWER); chk(val, 16'h0064);
    chk(dmode, 3'h4);
    count_high(1'b0, n);
    chkn(n > 0 && n < 24, 1);
    kok = 1'b0;
    count_high(1'b0, n); chkn(n, 0);
    n = n_wr;
    key(RAISE); chk(val, 16'h0064);
    chkn(n_wr, n);
    kok = 1'b1; ro = 1'b1;
    count_high(1'b0, n); chkn(n, 0);
    ro = 1'b0;
  endtask : t_value

  task automatic t_hex;
    hex = 1'b1;
    key(RAISE); chk(val, 16'h0065);
    n = n_wr;
    key(MODE | RAISE); chk(hdig, 2'h1);
    chkn(n_wr, n);
    key(MODE | RAISE); chk(hdig, 2'h2);
    key(LOWER); chk(val, 16'h0f65);
    hex = 1'b0; pmin = 16'h0010; pmax = 16'h0100;
    key(RAISE); chk(val, 16'h0010);
    key(LOWER); chk(val, 16'h0100);
    pmin = 16'h0000; pmax = 16'h03e8;
    // Held long enough for the press event plus one repeat
    opm_operator_inst.press(RAISE, 30);
    chk(val, 16'h0102);
  endtask : t_hex

  task automatic t_sets;
    aset = 2'h1; sen = 1'b1; sin = 2'h3;
    repeat (3) @(posedge clk);
    #2 chk(pset, 2'h0);
    chk(sshow, 1'b0);
    key(MODE); chk(dmode, 3'h2);
    goal = 10'h064; jump = 1'b1;
    // Search walks one number per cycle, so wait it out
    key(RAISE); repeat (120) @(posedge clk);
    #2 chk(num, 10'h064);
    chk(pset, 2'h3);
    chk(sshow, 1'b1);
    sen = 1'b0;
    repeat (3) @(posedge clk);
    #2 chk(pset, 2'h1);
    aset = 2'h0;
    repeat (3) @(posedge clk);
    #2 chk(sshow, 1'b0);
    goal = 10'h020;
    key(LOWER); repeat (120) @(posedge clk);
    #2 chk(num, 10'h020);
    pval = 16'h1234;
    key(MODE); chk(val, 16'h1234);
    count_high(1'b0, n); chkn(n, 0);
    key(RAISE); chk(val, 16'h1234);
    jump = 1'b0;
  endtask : t_sets

  task automatic t_cmds;
    smeth = 2'h2;
    key(HALT); chkn(n_sp, 1);
    chk(smo, 2'h2);
    key(BACK); chk(dmode, 3'h0);
    key(START); chkn(n_st, 0);
    src = 1'b1;
    key(START); chkn(n_st, 1);
    key(HALT); chkn(n_sp, 2);
  endtask : t_cmds

  task automatic t_leds;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) #1 {cont, regen, oper} = 3'(i);
      repeat (3) @(posedge clk);
      #2 chk(run_led, 1'(i == 7));
      chk(rdy_led, 1'(i == 4 || i == 5));
    end
    rev = 1'b1;
    repeat (3) @(posedge clk);
    #2 chk(rev_led, 1'b1);
    flt = 1'b1;
    repeat (3) @(posedge clk);
    count_high(1'b1, n); chkn(n, 24);
    flt = 1'b0; warn = 1'b1;
    count_high(1'b1, n); chkn(n > 0 && n < 24, 1);
  endtask : t_leds

  task automatic give_verdict;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  // Whole run is under two thousand cycles
  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    t_menu();
    t_number();
    t_index();
    t_value();
    t_hex();
    t_sets();
    t_cmds();
    t_leds();
    give_verdict();
  end
endmodule : testbench
